// file: include/cmp_ctl_defines.svh
// Purpose: Offsets, field positions, reset values and AXI response codes for the comparator control block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef CMP_CTL_DEFINES_SVH
`define CMP_CTL_DEFINES_SVH

// Register byte offsets
`define CFG_OFFSET        12'h000
`define LINK_OFFSET       12'h004
`define IRQ_FLAG_OFFSET   12'h008
`define IRQ_EN_OFFSET     12'h00C

// comparator_config fields
`define CFG_MODE_LSB      0
`define CFG_SWITCH_BIT    3
`define CFG_INV1_BIT      4
`define CFG_INV2_BIT      5
`define CFG_OUT1_BIT      6
`define CFG_OUT2_BIT      7

// comparator_timer_link fields
`define LINK_SYNC_BIT     0
`define LINK_GSS_BIT      1

// irq flag / enable fields
`define IRQ_C1_BIT        0
`define IRQ_C2_BIT        1
`define IRQ_PERIPHERAL_IRQ_ENABLE_BIT      2
`define IRQ_GIE_BIT       3

// Reset values
`define CFG_RESET         8'h00
`define LINK_RESET        8'h02

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: include/cmp_ctl_pkg.sv
// Purpose: Types for the comparator control block
// Assumes: Used with cmp_ctl_defines.svh
// Notes:   Mode encodings follow the three-bit mode field
package cmp_ctl_pkg;

  typedef enum logic [2:0] {
    MODE_OFF_ANALOG  = 3'h0,
    MODE_THREE_MUX   = 3'h1,
    MODE_FOUR_MUX    = 3'h2,
    MODE_COMMON_REF  = 3'h3,
    MODE_INDEPENDENT = 3'h4,
    MODE_SINGLE      = 3'h5,
    MODE_OUT_COMMON  = 3'h6,
    MODE_OFF_DIGITAL = 3'h7
  } compare_mode_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_e;

  typedef struct packed {
    logic          first_polarity_invert;
    logic          second_polarity_invert;
    logic          input_switch_select;
    compare_mode_e compare_mode_field;
  } config_s;

  // Analog front-end steering
  typedef struct packed {
    logic c1_enable;
    logic c2_enable;
    logic c1_inv_from_alt;  // C1 inverting input from alternate pin
    logic c2_inv_from_alt;  // C2 inverting input from alternate pin
    logic c2_pos_from_ref;  // C2 non-inverting input from fixed reference
    logic common_ref;       // C2 non-inverting input shared with C1
    logic pins_digital;     // Comparator input pins released to digital
  } analog_ctl_s;

endpackage

// file: hdl/dual_comparator_control.sv
// Purpose: Digital control of a dual analog comparator: modes, polarity, change interrupts, timer gate
// Assumes: Comparator raw outputs synchronous to i_mclk; each clock models one instruction cycle
// Notes:   Registers over AXI4-Lite; first clock phase sample modelled as every i_mclk edge
//          Change flags favour set over a software clear
`timescale 1ns/100ps
`include "cmp_ctl_defines.svh"

module dual_comparator_control #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]          i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  // AXI4-Lite write response
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]          i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  // AXI4-Lite read data
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  // Comparator analog side
  input  wire logic                       i_c1_raw,
  input  wire logic                       i_c2_raw,
  output cmp_ctl_pkg::analog_ctl_s        o_analog_ctl,
  // Output pins
  output logic [1:0]                      o_compare_output_pin,
  output logic [1:0]                      o_compare_output_pin_oe_n,
  // Timer gate
  input  wire logic                       i_external_gate_pin,
  input  wire logic                       i_timer_clk,
  output logic                            o_timer_gate,
  // System
  input  wire logic                       i_sleeping,
  output logic                            o_irq,
  output logic                            o_wake
);

  // Refuse address widths the decoder cannot hold
  if (ADDR_W < 4 || ADDR_W > 32) begin
    $error("ADDR_W out of range");
  end

  cmp_ctl_pkg::config_s   cfg_r;
  logic                   gss_r;
  logic                   sync_r;
  logic [1:0]             flag_r;
  logic [1:0]             en_r;
  logic                   peripheral_irq_enable_r;
  logic                   gie_r;
  // Change detection state
  logic [1:0]             read_latch_r;
  logic [1:0]             sample_r;
  logic [1:0]             mismatch;
  logic [1:0]             cmp_out;
  logic                   cmp_on;
  // Timer gate path
  logic                   timer_clk_d_r;
  logic                   c2_synced_r;
  // Register bus bookkeeping
  cmp_ctl_pkg::wr_state_e wr_state_r;
  logic                   aw_got_r;
  logic                   w_got_r;
  logic [ADDR_W-1:0]      awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   wr_fire;
  logic                   rd_fire;
  logic                   cfg_read;
  logic                   cfg_write;
  logic                   flag_write;
  logic                   en_write;
  logic                   link_write;
  logic [ADDR_W-1:0]      wr_addr;
  logic [31:0]            wr_data;

  // Map offset to a register index; unmapped returns 3'h4
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = 3'h4;
    if (a == ADDR_W'(`CFG_OFFSET)) begin
      idx = 3'h0;
    end else if (a == ADDR_W'(`LINK_OFFSET)) begin
      idx = 3'h1;
    end else if (a == ADDR_W'(`IRQ_FLAG_OFFSET)) begin
      idx = 3'h2;
    end else if (a == ADDR_W'(`IRQ_EN_OFFSET)) begin
      idx = 3'h3;
    end
    return idx;
  endfunction

  // Comparators off in modes 000 and 111, on otherwise, sleep or not
  assign cmp_on = (cfg_r.compare_mode_field != cmp_ctl_pkg::MODE_OFF_ANALOG) &&
                  (cfg_r.compare_mode_field != cmp_ctl_pkg::MODE_OFF_DIGITAL);

  // Polarity applied; off comparators read low
  assign cmp_out[0] = cmp_on & (i_c1_raw ^ cfg_r.first_polarity_invert);
  assign cmp_out[1] = cmp_on & (i_c2_raw ^ cfg_r.second_polarity_invert);

  // Write channel: take address and data in either order
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_got_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_got_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
    end
  end

  // Commit once both halves are held; response follows at that edge
  assign wr_fire = (wr_state_r == cmp_ctl_pkg::WR_IDLE) && aw_got_r && w_got_r;
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_state_r <= cmp_ctl_pkg::WR_IDLE;
      o_bvalid   <= 1'b0;
      o_bresp    <= `RESP_OKAY;
      o_awready  <= 1'b0;
      o_wready   <= 1'b0;
    end else begin
      // Registered readies: low from each handshake until the cycle after the response is taken
      o_awready <= (wr_state_r == cmp_ctl_pkg::WR_IDLE) && !aw_got_r && !(o_awready && i_awvalid) && !wr_fire;
      o_wready  <= (wr_state_r == cmp_ctl_pkg::WR_IDLE) && !w_got_r && !(o_wready && i_wvalid) && !wr_fire;
      case (wr_state_r)
        cmp_ctl_pkg::WR_IDLE: begin
          if (wr_fire) begin
            o_bvalid   <= 1'b1;
            o_bresp    <= (decode(wr_addr) == 3'h4) ? `RESP_SLVERR : `RESP_OKAY;
            wr_state_r <= cmp_ctl_pkg::WR_RESP;
          end
        end
        cmp_ctl_pkg::WR_RESP: begin
          if (i_bready) begin
            o_bvalid   <= 1'b0;
            wr_state_r <= cmp_ctl_pkg::WR_IDLE;
          end
        end
        default: wr_state_r <= cmp_ctl_pkg::WR_IDLE;
      endcase
    end
  end

  // Only the low byte lane carries register bits
  assign cfg_write  = wr_fire && (decode(wr_addr) == 3'h0) && wstrb_r[0];
  assign link_write = wr_fire && (decode(wr_addr) == 3'h1) && wstrb_r[0];
  assign flag_write = wr_fire && (decode(wr_addr) == 3'h2) && wstrb_r[0];
  assign en_write   = wr_fire && (decode(wr_addr) == 3'h3) && wstrb_r[0];

  // Read channel: one cycle to answer
  // One read in flight; arready stays low while data waits
  assign rd_fire  = o_arready && i_arvalid;
  assign cfg_read = rd_fire && (decode(i_araddr) == 3'h0);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !rd_fire;
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rresp  <= `RESP_OKAY;
        o_rdata  <= 32'h0000_0000;
        if (decode(i_araddr) == 3'h0) begin
          o_rdata[`CFG_OUT2_BIT]  <= cmp_out[1];
          o_rdata[`CFG_OUT1_BIT]  <= cmp_out[0];
          o_rdata[`CFG_INV2_BIT]  <= cfg_r.second_polarity_invert;
          o_rdata[`CFG_INV1_BIT]  <= cfg_r.first_polarity_invert;
          o_rdata[`CFG_SWITCH_BIT] <= cfg_r.input_switch_select;
          o_rdata[`CFG_MODE_LSB+2:`CFG_MODE_LSB] <= cfg_r.compare_mode_field;
        end else if (decode(i_araddr) == 3'h1) begin
          o_rdata[`LINK_GSS_BIT]  <= gss_r;
          o_rdata[`LINK_SYNC_BIT] <= sync_r;
        end else if (decode(i_araddr) == 3'h2) begin
          o_rdata[`IRQ_C2_BIT:`IRQ_C1_BIT] <= flag_r;
        end else if (decode(i_araddr) == 3'h3) begin
          o_rdata[`IRQ_C2_BIT:`IRQ_C1_BIT] <= en_r;
          o_rdata[`IRQ_PERIPHERAL_IRQ_ENABLE_BIT] <= peripheral_irq_enable_r;
          o_rdata[`IRQ_GIE_BIT]  <= gie_r;
        end else begin
          o_rresp <= `RESP_SLVERR;
        end
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cfg_r  <= cmp_ctl_pkg::config_s'(6'(`CFG_RESET));
      gss_r  <= 1'(`LINK_RESET >> `LINK_GSS_BIT);
      sync_r <= 1'b0;
    end else begin
      // Result bits are read only; writes to them are dropped
      if (cfg_write) begin
        cfg_r.second_polarity_invert <= wr_data[`CFG_INV2_BIT];
        cfg_r.first_polarity_invert  <= wr_data[`CFG_INV1_BIT];
        cfg_r.input_switch_select    <= wr_data[`CFG_SWITCH_BIT];
        cfg_r.compare_mode_field     <= cmp_ctl_pkg::compare_mode_e'(wr_data[`CFG_MODE_LSB+2:`CFG_MODE_LSB]);
      end
      if (link_write) begin
        gss_r  <= wr_data[`LINK_GSS_BIT];
        sync_r <= wr_data[`LINK_SYNC_BIT];
      end
    end
  end

  // Enables
  // Only a full low byte write moves them
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      en_r   <= 2'h0;
      peripheral_irq_enable_r <= 1'b0;
      gie_r  <= 1'b0;
    end else if (en_write) begin
      en_r   <= wr_data[`IRQ_C2_BIT:`IRQ_C1_BIT];
      peripheral_irq_enable_r <= wr_data[`IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
      gie_r  <= wr_data[`IRQ_GIE_BIT];
    end
  end

  // Mismatch latches, one pair per comparator
  // Write refreshes the read latch too, as it reads first
  // Change landing with a read enters both latches and is lost
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      read_latch_r <= 2'h0;
      sample_r     <= 2'h0;
    end else begin
      sample_r <= cmp_out;
      if (cfg_read || cfg_write) begin
        read_latch_r <= cmp_out;
      end
    end
  end

  assign mismatch = sample_r ^ read_latch_r;

  // Flags: mismatch wins over a software clear
  // Clear only lands once the mismatch has ended
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flag_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (mismatch[i]) begin
          flag_r[i] <= 1'b1;
        end else if (flag_write) begin
          flag_r[i] <= wr_data[`IRQ_C1_BIT + i];
        end
      end
    end
  end

  // Interrupt and wake requests
  // Flags still set with enables off; only requests gated
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq  <= |(flag_r & en_r) & peripheral_irq_enable_r & gie_r;
      o_wake <= |(flag_r & en_r) & peripheral_irq_enable_r & i_sleeping;
    end
  end

  // Analog steering and output pins
  // Comparator 1 idles in single comparator mode
  // Pins return to port use outside mode 110
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_analog_ctl              <= '0;
      o_compare_output_pin      <= 2'h0;
      o_compare_output_pin_oe_n <= 2'h3;
    end else begin
      o_analog_ctl.c1_enable       <= cmp_on && (cfg_r.compare_mode_field != cmp_ctl_pkg::MODE_SINGLE);
      o_analog_ctl.c2_enable       <= cmp_on;
      o_analog_ctl.c1_inv_from_alt <= cfg_r.input_switch_select &&
                                      (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_THREE_MUX ||
                                       cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_FOUR_MUX);
      o_analog_ctl.c2_inv_from_alt <= cfg_r.input_switch_select &&
                                      (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_FOUR_MUX);
      o_analog_ctl.c2_pos_from_ref <= cfg_r.input_switch_select &&
                                      (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_SINGLE);
      o_analog_ctl.common_ref      <= (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_COMMON_REF ||
                                       cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_OUT_COMMON);
      o_analog_ctl.pins_digital    <= (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_OFF_DIGITAL);
      if (cfg_r.compare_mode_field == cmp_ctl_pkg::MODE_OUT_COMMON) begin
        o_compare_output_pin      <= cmp_out;
        o_compare_output_pin_oe_n <= 2'h0;
      end else begin
        o_compare_output_pin      <= 2'h0;
        o_compare_output_pin_oe_n <= 2'h3;
      end
    end
  end

  // Comparator 2 latched at timer clock falling edge (sampled)
  // Gate stays still while the timer counts on the rising edge
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      timer_clk_d_r <= 1'b0;
      c2_synced_r   <= 1'b0;
      o_timer_gate  <= 1'b1;
    end else begin
      timer_clk_d_r <= i_timer_clk;
      if (timer_clk_d_r && !i_timer_clk) begin
        c2_synced_r <= cmp_out[1];
      end
      if (gss_r) begin
        o_timer_gate <= i_external_gate_pin;
      end else begin
        o_timer_gate <= sync_r ? c2_synced_r : cmp_out[1];
      end
    end
  end

endmodule

// file: test/cmp_far_side_model.sv
// Purpose: Far side of the comparator block: analog results, gate pin, timer clock
// Assumes: Bench requests levels; outputs follow one i_mclk edge later
// Notes:   Timer clock stands still unless the bench moves it
`timescale 1ns/100ps
module cmp_far_side_model (
  // Clock
  input  wire logic i_mclk,
  // Requests
  input  wire logic i_c1_req,
  input  wire logic i_c2_req,
  input  wire logic i_gate_req,
  input  wire logic i_tclk_req,
  // Far side levels
  output logic      o_c1_raw,
  output logic      o_c2_raw,
  output logic      o_gate_pin,
  output logic      o_timer_clk
);
  initial {o_c1_raw, o_c2_raw, o_gate_pin, o_timer_clk} = 4'h0;
  always @(posedge i_mclk) begin
    o_c1_raw    <= i_c1_req;
    o_c2_raw    <= i_c2_req;
    o_gate_pin  <= i_gate_req;
    o_timer_clk <= i_tclk_req;
  end
endmodule

// file: test/dual_comparator_control_asserts.sv
// Purpose: Port-level checks of the comparator control block
// Assumes: Single clock domain
// Notes:   Bound to every instance of the block
`timescale 1ns/100ps
module dual_comparator_control_asserts (
  input wire logic                     i_mclk,
  input wire logic                     i_rst,
  input wire logic                     o_awready,
  input wire logic                     i_awvalid,
  input wire logic                     o_wready,
  input wire logic                     i_wvalid,
  input wire logic                     o_bvalid,
  input wire logic [1:0]               o_bresp,
  input wire logic                     i_bready,
  input wire logic                     o_rvalid,
  input wire logic [31:0]              o_rdata,
  input wire logic                     i_rready,
  input wire cmp_ctl_pkg::analog_ctl_s o_analog_ctl,
  input wire logic [1:0]               o_compare_output_pin,
  input wire logic [1:0]               o_compare_output_pin_oe_n,
  input wire logic                     i_sleeping,
  input wire logic                     o_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_bhold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wresp;
    o_awready && i_awvalid && o_wready && i_wvalid |-> ##2 o_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write response late");
  property p_off;
    o_analog_ctl.pins_digital |-> !o_analog_ctl.c1_enable && !o_analog_ctl.c2_enable;
  endproperty
  a_off: assert property (p_off) else $error("comparator on in digital off mode");
  property p_pins;
    (o_compare_output_pin_oe_n == 2'h0 || o_compare_output_pin_oe_n == 2'h3) &&
    (o_compare_output_pin_oe_n == 2'h0 || o_compare_output_pin == 2'h0);
  endproperty
  a_pins: assert property (p_pins) else $error("output pins driven apart");
  property p_wake;
    o_wake |-> $past(i_sleeping);
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_ref;
    o_analog_ctl.c2_pos_from_ref |-> o_analog_ctl.c2_enable && !o_analog_ctl.c1_enable;
  endproperty
  a_ref: assert property (p_ref) else $error("reference steering outside single mode");
  property p_common;
    o_analog_ctl.common_ref |-> o_analog_ctl.c1_enable && o_analog_ctl.c2_enable;
  endproperty
  a_common: assert property (p_common) else $error("common reference with comparator off");
  property p_rst;
    $fell(i_rst) |-> o_analog_ctl == 7'h00 && o_compare_output_pin_oe_n == 2'h3;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset state");
endmodule
bind dual_comparator_control dual_comparator_control_asserts u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .o_awready(o_awready), .i_awvalid(i_awvalid),
  .o_wready(o_wready), .i_wvalid(i_wvalid), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
  .i_bready(i_bready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_rready(i_rready),
  .o_analog_ctl(o_analog_ctl), .o_compare_output_pin(o_compare_output_pin),
  .o_compare_output_pin_oe_n(o_compare_output_pin_oe_n),
  .i_sleeping(i_sleeping), .o_wake(o_wake));

// file: test/dual_comparator_control_tb.sv
// Purpose: Self-checking bench for the comparator control block
// Assumes: AXI4-Lite master tasks, far side model for analog and timer
// Notes:   Random inversion, sleep and pin levels from a fixed seed
`timescale 1ns/100ps
`include "cmp_ctl_defines.svh"
module dual_comparator_control_tb;
  logic        i_mclk = 1'h0, i_rst = 1'h1;
  logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic [3:0]  i_wstrb = 4'hF;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic        i_sleeping = 1'h0, c1_req = 1'h0, c2_req = 1'h0, gate_req = 1'h0, tclk_req = 1'h0;
  logic        c1v = 1'h0, c2v = 1'h0;
  wire logic   i_c1_raw, i_c2_raw, i_external_gate_pin, i_timer_clk;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_timer_gate, o_irq, o_wake;
  logic [1:0]  o_bresp, o_rresp, o_compare_output_pin, o_compare_output_pin_oe_n;
  cmp_ctl_pkg::analog_ctl_s o_analog_ctl;
  int          errors = 0, compares = 0;

  always #25 i_mclk = ~i_mclk;

  cmp_far_side_model u_cmp_far_side_model (.i_mclk(i_mclk), .i_c1_req(c1_req), .i_c2_req(c2_req),
    .i_gate_req(gate_req), .i_tclk_req(tclk_req), .o_c1_raw(i_c1_raw), .o_c2_raw(i_c2_raw),
    .o_gate_pin(i_external_gate_pin), .o_timer_clk(i_timer_clk));
  dual_comparator_control u_dual_comparator_control (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_c1_raw(i_c1_raw), .i_c2_raw(i_c2_raw), .o_analog_ctl(o_analog_ctl),
    .o_compare_output_pin(o_compare_output_pin), .o_compare_output_pin_oe_n(o_compare_output_pin_oe_n),
    .i_external_gate_pin(i_external_gate_pin), .i_timer_clk(i_timer_clk), .o_timer_gate(o_timer_gate),
    .i_sleeping(i_sleeping), .o_irq(o_irq), .o_wake(o_wake));

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    forever begin
      @(posedge i_mclk);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'h0;
      if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      if (o_bvalid && i_bready) begin
        chk(o_bresp, er);
        break;
      end
      if (n > 60) begin
        errors++;
        break;
      end
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    forever begin
      @(posedge i_mclk);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      if (o_rvalid && i_rready) begin
        chk(o_rdata, e);
        chk(o_rresp, er);
        break;
      end
      if (n > 60) begin
        errors++;
        break;
      end
    end
  endtask
  task automatic drive(input logic a, input logic b);
    c1_req <= a; c2_req <= b; c1v = a; c2v = b;
  endtask
  function automatic logic [31:0] actl(input logic [2:0] m, input logic s);
    return {25'h0, !(m == 3'h0 || m == 3'h7 || m == 3'h5), !(m == 3'h0 || m == 3'h7),
      s && (m == 3'h1 || m == 3'h2), s && m == 3'h2, s && m == 3'h5, m == 3'h3 || m == 3'h6, m == 3'h7};
  endfunction
  function automatic logic [31:0] cfg4();
    return {24'h0, c2v, c1v, 6'h04};
  endfunction

  initial begin
    repeat (30000) @(posedge i_mclk);
    errors++;
    summarize();
  end

  initial begin
    v = $urandom(32'h830C);
    cyc(20);
    i_rst <= 1'h0;
    cyc(1);
    rdc(`CFG_OFFSET, 32'h0);
    rdc(`LINK_OFFSET, 32'h2);
    rdc(12'h010, 32'h0, `RESP_SLVERR);
    wr(12'h010, 8'hFF, `RESP_SLVERR);
    for (int m = 0; m < 8; m++) begin
      wr(`CFG_OFFSET, 8'h08 | m[7:0]);
      cyc(2);
      chk(o_analog_ctl, actl(m[2:0], 1'h1));
      chk(o_compare_output_pin_oe_n, (m == 6) ? 2'h0 : 2'h3);
      rdc(`CFG_OFFSET, 32'h08 | m);
    end
    wr(`IRQ_EN_OFFSET, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      drive(v[0], v[1]);
      wr(`CFG_OFFSET, {2'h0, v[3:2], 4'h4});
      cyc(4);
      rdc(`CFG_OFFSET, {24'h0, v[1] ^ v[3], v[0] ^ v[2], v[3:2], 4'h4});
    end
    wr(`CFG_OFFSET, 8'h04);
    cyc(20);
    rdc(`CFG_OFFSET, cfg4());
    wr(`IRQ_FLAG_OFFSET, 8'h00);
    rdc(`IRQ_FLAG_OFFSET, 32'h0);
    drive(~c1v, c2v);
    cyc(5);
    rdc(`IRQ_FLAG_OFFSET, 32'h1);
    wr(`IRQ_FLAG_OFFSET, 8'h00);
    rdc(`IRQ_FLAG_OFFSET, 32'h1);
    rdc(`CFG_OFFSET, cfg4());
    wr(`IRQ_FLAG_OFFSET, 8'h00);
    rdc(`IRQ_FLAG_OFFSET, 32'h0);
    drive(c1v, ~c2v);
    cyc(4);
    drive(c1v, ~c2v);
    cyc(4);
    rdc(`IRQ_FLAG_OFFSET, 32'h2);
    wr(`IRQ_FLAG_OFFSET, 8'h00);
    rdc(`IRQ_FLAG_OFFSET, 32'h0);
    drive(~c1v, c2v);
    cyc(4);
    wr(`CFG_OFFSET, 8'h04);
    wr(`IRQ_FLAG_OFFSET, 8'h00);
    rdc(`IRQ_FLAG_OFFSET, 32'h0);
    wr(`IRQ_FLAG_OFFSET, 8'h03);
    rdc(`IRQ_FLAG_OFFSET, 32'h3);
    wr(`IRQ_FLAG_OFFSET, 8'h01);
    for (int e = 0; e < 16; e++) begin
      v = $urandom;
      i_sleeping <= v[0];
      wr(`IRQ_EN_OFFSET, e[7:0]);
      cyc(3);
      chk(o_irq, e[0] & e[2] & e[3]);
      chk(o_wake, e[0] & e[2] & v[0]);
    end
    rdc(`IRQ_FLAG_OFFSET, 32'h1);
    i_sleeping <= 1'h0;
    wr(`IRQ_EN_OFFSET, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      gate_req <= v[0];
      cyc(4);
      chk(o_timer_gate, v[0]);
    end
    tclk_req <= 1'h1;
    wr(`LINK_OFFSET, 8'h01);
    for (int b = 0; b < 2; b++) begin
      drive(c1v, b[0]);
      cyc(4);
      tclk_req <= 1'h0;
      cyc(4);
      chk(o_timer_gate, b[0]);
      tclk_req <= 1'h1;
      cyc(4);
    end
    drive(c1v, 1'h0);
    cyc(6);
    chk(o_timer_gate, 32'h1);
    wr(`LINK_OFFSET, 8'h00);
    cyc(4);
    chk(o_timer_gate, 32'h0);
    wr(`CFG_OFFSET, 8'h06);
    drive(1'h1, 1'h0);
    cyc(4);
    chk(o_compare_output_pin, 2'h1);
    wr(`CFG_OFFSET, 8'h00);
    drive(1'h1, 1'h1);
    cyc(4);
    rdc(`CFG_OFFSET, 32'h0);
    i_wstrb <= 4'h0;
    wr(`CFG_OFFSET, 8'h07);
    i_wstrb <= 4'hF;
    rdc(`CFG_OFFSET, 32'h0);
    wr(`CFG_OFFSET, 8'h35);
    wr(`IRQ_FLAG_OFFSET, 8'h03);
    i_rst <= 1'h1;
    cyc(3);
    i_rst <= 1'h0;
    cyc(1);
    rdc(`CFG_OFFSET, 32'h0);
    rdc(`LINK_OFFSET, 32'h2);
    rdc(`IRQ_FLAG_OFFSET, 32'h0);
    summarize();
  end
endmodule
